// [rtl/tt_timer_ctrl.sv]
`timescale 1ns/10ps
module tt_timer_ctrl #(
    parameter int TICK_DIV = tt_pkg::TICK_DIV_DEF,
    parameter int ADDR_W = 12
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Counter and other timer.
    input wire logic counter_overflow,
    input wire logic other_overflow,
    input wire logic up_down_enable,
    input wire logic timer_int_enable,
    // Pins.
    input wire logic trigger_input_pin,
    input wire logic event_input_pin,
    // Counter controls.
    output logic count_tick,
    output logic reload_strobe,
    output logic capture_strobe,
    // Serial port clocks.
    output logic rx_baud_clk,
    output logic tx_baud_clk,
    // Interrupts.
    output logic timer_irq,
    output logic irq
);
    // ****************************************
    // Parameter checks.
    // ****************************************
    localparam int DIV_W = $clog2(TICK_DIV + 1);

    // Refuse a divider of zero or an address too narrow for the map.
    if (TICK_DIV < 1 || ADDR_W < 12) begin : g_bad_param
        $error("tt_timer_ctrl: TICK_DIV must be >= 1 and ADDR_W >= 12");
    end

    // ****************************************
    // Declarations.
    // ****************************************
    logic [7:0] ctrl_q; // Control register.
    logic [DIV_W-1:0] div_q; // Internal tick divider.
    logic div_hit; // Divider wraps this cycle.
    logic trig_fall; // Falling edge on the trigger pin.
    logic ev_fall; // Falling edge on the event pin.
    logic baud_sel; // Either baud select is set.
    logic cap_mode; // Capture mode in effect.
    logic trig_evt; // Enabled trigger edge.
    logic ovf_set; // Overflow that may set the flag.
    logic acc; // Completing APB access.
    logic wr_ok; // Write with low byte lane.
    logic hit_ctrl; // Address hits control.
    logic hit_stat; // Address hits status.
    logic hit_mask; // Address hits mask.
    logic [31:0] rd_d; // Read data for the setup address.
    logic [31:0] prdata_q; // Registered read data.
    logic pready_q; // Registered ready.
    logic pslverr_q; // Registered error.
    logic count_tick_q; // Count enable pulse.
    logic reload_q; // Reload pulse.
    logic capture_q; // Capture pulse.
    logic rx_baud_q; // Receive baud pulse.
    logic tx_baud_q; // Transmit baud pulse.
    logic timer_irq_q; // Timer interrupt request.

    tt_evt_if evt ();

    // ****************************************
    // Pin edge detection.
    // ****************************************
    // Trigger pin edges drive captures and reloads.
    tt_fall_det #(
        .IDLE(1'b1)
    ) u_trig_det (
        .clk(clk),
        .rst_b(rst_b),
        .pin(trigger_input_pin),
        .fall(trig_fall)
    );

    // Event pin edges are counted in counter mode.
    tt_fall_det #(
        .IDLE(1'b1)
    ) u_event_det (
        .clk(clk),
        .rst_b(rst_b),
        .pin(event_input_pin),
        .fall(ev_fall)
    );

    // ****************************************
    // Mode decode.
    // ****************************************
    assign baud_sel = ctrl_q[tt_pkg::RXS_BIT] | ctrl_q[tt_pkg::TXS_BIT];
    // A baud select overrides the capture choice.
    assign cap_mode = ctrl_q[tt_pkg::CRS_BIT] & ~baud_sel;
    // Only an enabled trigger edge acts.
    assign trig_evt = trig_fall & ctrl_q[tt_pkg::TEN_BIT];
    // Overflow does not flag while the timer feeds the serial port.
    assign ovf_set = counter_overflow & ~baud_sel;

    // ****************************************
    // APB decode.
    // ****************************************
    assign acc = psel & penable & pready_q;
    assign wr_ok = acc & pwrite & pstrb[0];
    assign hit_ctrl = paddr[11:0] == tt_pkg::CTRL_OFF;
    assign hit_stat = paddr[11:0] == tt_pkg::STAT_OFF;
    assign hit_mask = paddr[11:0] == tt_pkg::MASK_OFF;

    // Select the read word; unused bits read as zero.
    always_comb begin
        rd_d = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_d[7:0] = ctrl_q;
        end else if (hit_stat) begin
            rd_d[1:0] = evt.status;
        end else if (hit_mask) begin
            rd_d[1:0] = evt.mask;
        end
    end

    // Answer in the cycle after setup; read data are taken at setup.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel & ~penable;
            if (psel && !penable) begin
                pslverr_q <= ~(hit_ctrl | hit_stat | hit_mask);
                prdata_q <= rd_d;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Control register.
    // ****************************************
    // Software writes store; hardware sets win over a clear.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= tt_pkg::CTRL_RST;
        end else begin
            if (wr_ok && hit_ctrl) begin
                ctrl_q <= pwdata[7:0];
            end
            if (ovf_set) begin
                ctrl_q[tt_pkg::OVF_BIT] <= 1'b1;
            end
            if (trig_evt) begin
                ctrl_q[tt_pkg::EXT_BIT] <= 1'b1;
            end
        end
    end

    // ****************************************
    // Event status and mask.
    // ****************************************
    assign evt.ev_set = {trig_evt, ovf_set};
    assign evt.ev_clr = (wr_ok && hit_stat) ? pwdata[1:0] : 2'h0;
    assign evt.mask_we = wr_ok & hit_mask;
    assign evt.mask_wdata = pwdata[1:0];

    // Sticky status, mask and the summary line.
    tt_irq_ctl u_irq (
        .clk(clk),
        .rst_b(rst_b),
        .evt(evt),
        .irq(irq)
    );

    // ****************************************
    // Count source.
    // ****************************************
    assign div_hit = div_q == DIV_W'(TICK_DIV - 1);

    // Free-running divider for the internal tick.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= '0;
        end else if (div_hit) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DIV_W'(1);
        end
    end

    // Tick from the divider or the event pin, only while running.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_tick_q <= 1'b0;
        end else if (!ctrl_q[tt_pkg::RUN_BIT]) begin
            count_tick_q <= 1'b0;
        end else if (ctrl_q[tt_pkg::CSS_BIT]) begin
            count_tick_q <= ev_fall;
        end else begin
            count_tick_q <= div_hit;
        end
    end

    // ****************************************
    // Capture and reload.
    // ****************************************
    // Capture on trigger edges; otherwise reload on overflow or edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            capture_q <= 1'b0;
            reload_q <= 1'b0;
        end else begin
            capture_q <= trig_evt & cap_mode;
            reload_q <= ~cap_mode & (counter_overflow | trig_evt);
        end
    end

    // ****************************************
    // Serial baud clocks.
    // ****************************************
    // Each direction picks our overflow or the other timer's.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_baud_q <= 1'b0;
            tx_baud_q <= 1'b0;
        end else begin
            if (ctrl_q[tt_pkg::RXS_BIT]) begin
                rx_baud_q <= counter_overflow;
            end else begin
                rx_baud_q <= other_overflow;
            end
            if (ctrl_q[tt_pkg::TXS_BIT]) begin
                tx_baud_q <= counter_overflow;
            end else begin
                tx_baud_q <= other_overflow;
            end
        end
    end

    // ****************************************
    // Timer interrupt request.
    // ****************************************
    // Either flag asks; the trigger flag is silent in up/down mode.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            timer_irq_q <= 1'b0;
        end else begin
            timer_irq_q <= timer_int_enable & (ctrl_q[tt_pkg::OVF_BIT] |
                (ctrl_q[tt_pkg::EXT_BIT] & ~up_down_enable));
        end
    end

    // ****************************************
    // Outputs.
    // ****************************************
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign count_tick = count_tick_q;
    assign reload_strobe = reload_q;
    assign capture_strobe = capture_q;
    assign rx_baud_clk = rx_baud_q;
    assign tx_baud_clk = tx_baud_q;
    assign timer_irq = timer_irq_q;

    // ****************************************
    // Checks.
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // A flagging overflow sets the flag next cycle.
    a_ovf_flag_set: assert property (ovf_set |=> ctrl_q[tt_pkg::OVF_BIT])
        else $error("overflow flag not set");
    // Only a software write of zero clears the flag.
    a_ovf_flag_hold: assert property (ctrl_q[tt_pkg::OVF_BIT] &&
        !(wr_ok && hit_ctrl && !pwdata[tt_pkg::OVF_BIT]) |=> ctrl_q[tt_pkg::OVF_BIT])
        else $error("overflow flag cleared by hardware");
    // Overflow in baud mode leaves a clear flag clear.
    a_ovf_baud_block: assert property (counter_overflow && baud_sel &&
        !ctrl_q[tt_pkg::OVF_BIT] && !(wr_ok && hit_ctrl) |=> !ctrl_q[tt_pkg::OVF_BIT])
        else $error("overflow flag set in baud mode");
    // An enabled falling trigger edge sets the trigger flag.
    a_ext_flag_set: assert property ($fell(trigger_input_pin) &&
        ctrl_q[tt_pkg::TEN_BIT] |=> ctrl_q[tt_pkg::EXT_BIT])
        else $error("trigger flag not set");
    // The trigger flag raises the enabled request.
    a_ext_irq_req: assert property (ctrl_q[tt_pkg::EXT_BIT] && timer_int_enable &&
        !up_down_enable |=> timer_irq)
        else $error("trigger flag gives no request");
    // In up/down mode the trigger flag alone stays silent.
    a_ext_no_irq: assert property (up_down_enable &&
        !ctrl_q[tt_pkg::OVF_BIT] |=> !timer_irq)
        else $error("trigger flag interrupts in up/down mode");
    // Receive clock follows our overflow when selected.
    a_rx_own_src: assert property (ctrl_q[tt_pkg::RXS_BIT] |=>
        rx_baud_clk == $past(counter_overflow))
        else $error("receive clock not from own overflow");
    // Receive clock follows the other timer otherwise.
    a_rx_other_src: assert property (!ctrl_q[tt_pkg::RXS_BIT] |=>
        rx_baud_clk == $past(other_overflow))
        else $error("receive clock not from other timer");
    // An enabled edge in capture mode captures and does not reload.
    a_capture_edge: assert property ($fell(trigger_input_pin) &&
        ctrl_q[tt_pkg::TEN_BIT] && cap_mode |=> capture_strobe && !reload_strobe)
        else $error("capture missing");
    // Overflow in reload mode reloads.
    a_reload_ovf: assert property (counter_overflow &&
        !ctrl_q[tt_pkg::CRS_BIT] |=> reload_strobe)
        else $error("reload on overflow missing");
    // Baud mode forces reload and never captures.
    a_force_reload: assert property (baud_sel && counter_overflow |=>
        reload_strobe && !capture_strobe)
        else $error("baud mode did not force reload");
    // Transmit clock follows the selected source.
    a_tx_src: assert property (1'b1 |=> tx_baud_clk == ($past(ctrl_q[tt_pkg::TXS_BIT])
        ? $past(counter_overflow) : $past(other_overflow)))
        else $error("transmit clock from wrong source");
    // A stopped timer gives no ticks; event mode counts pin edges.
    a_run_count: assert property (ctrl_q[tt_pkg::RUN_BIT] && ctrl_q[tt_pkg::CSS_BIT]
        |=> count_tick == $past(ev_fall))
        else $error("event count tick wrong");
    a_stop_count: assert property (!ctrl_q[tt_pkg::RUN_BIT] |=> !count_tick)
        else $error("tick while stopped");
endmodule // tt_timer_ctrl

// [rtl/tt_pkg.sv]
// ****************************************
// Shared constants of the timer control.
// ****************************************
package tt_pkg;
    // Byte offsets of the registers.
    localparam logic [11:0] CTRL_OFF = 12'h0c8;
    localparam logic [11:0] STAT_OFF = 12'h0cc;
    localparam logic [11:0] MASK_OFF = 12'h0d0;
    // Bit positions in the control register.
    localparam int OVF_BIT = 7;
    localparam int EXT_BIT = 6;
    localparam int RXS_BIT = 5;
    localparam int TXS_BIT = 4;
    localparam int TEN_BIT = 3;
    localparam int RUN_BIT = 2;
    localparam int CSS_BIT = 1;
    localparam int CRS_BIT = 0;
    // Values after reset.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [1:0] STAT_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    // Event bits in the status and mask registers.
    localparam int EV_OVF = 0;
    localparam int EV_TRG = 1;
    localparam int EV_N = 2;
    // System clocks per internal count tick.
    localparam int TICK_DIV_DEF = 12;
endpackage : tt_pkg

// [rtl/tt_evt_if.sv]
`timescale 1ns/10ps
// ****************************************
// Event link between control and interrupt logic.
// ****************************************
interface tt_evt_if;
    logic [1:0] ev_set; // One-cycle event pulses.
    logic [1:0] ev_clr; // Write-one-to-clear pulses.
    logic mask_we; // Mask write strobe.
    logic [1:0] mask_wdata; // New mask value.
    logic [1:0] status; // Sticky status bits.
    logic [1:0] mask; // Current mask.
    modport src (output ev_set, ev_clr, mask_we, mask_wdata, input status, mask);
    modport sink (input ev_set, ev_clr, mask_we, mask_wdata, output status, mask);
endinterface : tt_evt_if

// [rtl/tt_fall_det.sv]
`timescale 1ns/10ps
// ****************************************
// Falling edge detector for a pin input.
// ****************************************
module tt_fall_det #(
    parameter logic IDLE = 1'b1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Pin and edge.
    input wire logic pin,
    output logic fall
);
    logic prev_q; // Pin level one cycle ago.

    // Remember the last level; reset to the idle level so no false edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= IDLE;
        end else begin
            prev_q <= pin;
        end
    end

    // A high-to-low change is a falling edge.
    assign fall = prev_q & ~pin;
endmodule // tt_fall_det

// [rtl/tt_irq_ctl.sv]
`timescale 1ns/10ps
// ****************************************
// Sticky status, mask and interrupt line.
// ****************************************
module tt_irq_ctl (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Event link.
    tt_evt_if.sink evt,
    // Interrupt line.
    output logic irq
);
    logic [1:0] status_q; // Sticky event bits.
    logic [1:0] mask_q; // Enable per event.
    logic irq_q; // Registered interrupt level.

    // Events set, writes of one clear; a set in the clear cycle wins.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_q <= tt_pkg::STAT_RST;
        end else begin
            status_q <= (status_q & ~evt.ev_clr) | evt.ev_set;
        end
    end

    // The mask is plain storage.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_q <= tt_pkg::MASK_RST;
        end else if (evt.mask_we) begin
            mask_q <= evt.mask_wdata;
        end
    end

    // The line is high while any unmasked bit is set.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
        end
    end

    assign evt.status = status_q;
    assign evt.mask = mask_q;
    assign irq = irq_q;

    // The line follows the gated status one cycle later.
    a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
        irq_q == $past(|(status_q & mask_q)))
        else $error("interrupt line does not follow masked status");
    // A set overflow status bit (bit 0) stays until cleared.
    a_sticky_hold: assert property (@(posedge clk) disable iff (!rst_b)
        status_q[0] && !evt.ev_clr[0] |=> status_q[0])
        else $error("sticky status bit lost");
endmodule // tt_irq_ctl

// [testbench/tt_pin_model.sv]
`timescale 1ns/10ps
// ****************************************
// Model of the trigger and event pins.
// ****************************************
module tt_pin_model (
    // Clock.
    input wire logic clk,
    // Pins towards the block.
    output logic trigger_input_pin,
    output logic event_input_pin
);
    // Both pins rest high, as pulled-up port pins do.
    initial begin
        trigger_input_pin = 1'b1;
        event_input_pin = 1'b1;
    end
    // Pulls one pin low for a chosen number of clocks, then lets it go high.
    task fall(input logic evt, input int hold);
        @(posedge clk);
        if (evt) begin
            event_input_pin <= 1'b0;
        end else begin
            trigger_input_pin <= 1'b0;
        end
        repeat (hold) @(posedge clk);
        event_input_pin <= 1'b1;
        trigger_input_pin <= 1'b1;
    endtask
endmodule // tt_pin_model

// [testbench/test_timer2_control_logic.sv]
`timescale 1ns/10ps
// ****************************************
// Self-checking bench of the timer control block.
// ****************************************
module test_timer2_control_logic;
    logic clk = 1'b0;
    logic rst_b, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0] pstrb;
    logic counter_overflow, other_overflow, up_down_enable, timer_int_enable;
    logic trigger_input_pin, event_input_pin, count_tick, reload_strobe, capture_strobe;
    logic rx_baud_clk, tx_baud_clk, timer_irq, irq;
    logic [32:0] notes[$]; // Expected {error, read data}, oldest first.
    logic [32:0] note;
    logic [7:0] c;
    int n_fail = 0;
    int checks = 0;
    int n_tk, n_rl, n_cp, n_rx, n_tx; // Pulses seen in the current window.
    // The clock toggles every half period of 5 ns.
    always #5 clk = ~clk;
    tt_timer_ctrl #(.TICK_DIV(2), .ADDR_W(12)) dut_u (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .counter_overflow(counter_overflow), .other_overflow(other_overflow),
        .up_down_enable(up_down_enable), .timer_int_enable(timer_int_enable),
        .trigger_input_pin(trigger_input_pin), .event_input_pin(event_input_pin),
        .count_tick(count_tick), .reload_strobe(reload_strobe),
        .capture_strobe(capture_strobe), .rx_baud_clk(rx_baud_clk),
        .tx_baud_clk(tx_baud_clk), .timer_irq(timer_irq), .irq(irq));
    tt_pin_model pm_u (.clk(clk), .trigger_input_pin(trigger_input_pin),
        .event_input_pin(event_input_pin));
    // ****************************************
    // Checking and reporting.
    // ****************************************
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task final_report();
        $display("comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Each completed transfer takes the oldest note and compares error, and read data for reads.
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (notes.size() == 0) begin
                n_fail++;
                $display("unexpected transfer: expected none, seen one");
            end else begin
                note = notes.pop_front();
                chk("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
                if (pwrite == 1'b0) begin
                    chk("prdata", note[31:0], prdata);
                end
            end
        end
    end
    // Strobes are counted at the falling edge, where they have settled.
    always @(negedge clk) begin
        n_tk += (count_tick === 1'b1);
        n_rl += (reload_strobe === 1'b1);
        n_cp += (capture_strobe === 1'b1);
        n_rx += (rx_baud_clk === 1'b1);
        n_tx += (tx_baud_clk === 1'b1);
    end
    // Watchdog: far beyond the few hundred cycles the tests need.
    initial begin
        #200000;
        n_fail++;
        $display("unexpected watchdog: expected end of tests, seen timeout");
        final_report();
    end
    // ****************************************
    // Bus and event drivers.
    // ****************************************
    // One APB transfer; the request is held until pready is sampled high.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] v, input logic [3:0] s,
        input logic [32:0] exp);
        int n;
        notes.push_back(exp);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16) begin
            n_fail++;
            $display("unexpected pready: expected 1, seen %b", pready);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] v);
        apb(1'b1, a, v, 4'hf, 33'h0);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'hf, {1'b0, exp});
    endtask
    // One event (0 overflow, 1 other overflow, 2 trigger, 3 event pin, 4 none), then a wait.
    task ev(input int k);
        // Let one edge pass so strobes launched under the old control value are not counted.
        @(posedge clk);
        n_tk = 0;
        n_rl = 0;
        n_cp = 0;
        n_rx = 0;
        n_tx = 0;
        if (k >= 2 && k <= 3) begin
            pm_u.fall(k == 3, k);
        end else begin
            @(posedge clk);
            counter_overflow <= (k == 0);
            other_overflow <= (k == 1);
        end
        @(posedge clk);
        counter_overflow <= 1'b0;
        other_overflow <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task clean();
        wr(tt_pkg::CTRL_OFF, 32'h0);
        wr(tt_pkg::STAT_OFF, 32'h3);
    endtask
    // ****************************************
    // Test sequence.
    // ****************************************
    initial begin
        {psel, penable, pwrite, counter_overflow, other_overflow, up_down_enable} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        timer_int_enable = 1'b1;
        rst_b = 1'b0;
        void'($urandom(29852));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values, unmapped place and random control values.
        rd(tt_pkg::CTRL_OFF, 32'h0);
        rd(tt_pkg::STAT_OFF, 32'h0);
        rd(tt_pkg::MASK_OFF, 32'h0);
        apb(1'b0, 12'h0d4, 32'h0, 4'hf, {1'b1, 32'h0});
        apb(1'b1, 12'h0d4, 32'h5a, 4'hf, {1'b1, 32'h0});
        repeat (4) begin
            d = $urandom;
            wr(tt_pkg::CTRL_OFF, d);
            rd(tt_pkg::CTRL_OFF, {24'h0, d[7:0]});
        end
        apb(1'b1, tt_pkg::CTRL_OFF, ~d, 4'he, 33'h0);
        rd(tt_pkg::CTRL_OFF, {24'h0, d[7:0]});
        clean();
        $display("test registers done");
        // Overflow in reload mode, sticky flag and masked interrupt.
        wr(tt_pkg::CTRL_OFF, 32'h04);
        ev(0);
        chk("reload_strobe count", 32'h1, n_rl);
        rd(tt_pkg::STAT_OFF, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        chk("timer_irq", 32'h1, {31'h0, timer_irq});
        wr(tt_pkg::MASK_OFF, 32'h1);
        repeat (20) @(posedge clk);
        chk("irq", 32'h1, {31'h0, irq});
        rd(tt_pkg::CTRL_OFF, 32'h84);
        wr(tt_pkg::STAT_OFF, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        wr(tt_pkg::CTRL_OFF, 32'h04);
        rd(tt_pkg::CTRL_OFF, 32'h04);
        clean();
        $display("test overflow done");
        // Baud selects against overflow of this timer and of the other one.
        for (int i = 0; i < 4; i++) begin
            c = {2'b00, i[1], i[0], 4'h1};
            wr(tt_pkg::CTRL_OFF, {24'h0, c});
            ev(0);
            chk("reload_strobe count", i[1] || i[0], n_rl);
            chk("rx_baud_clk count", i[1], n_rx);
            chk("tx_baud_clk count", i[0], n_tx);
            rd(tt_pkg::CTRL_OFF, {24'h0, c | {!(i[1] || i[0]), 7'h0}});
            ev(1);
            chk("rx_baud_clk count", !i[1], n_rx);
            chk("tx_baud_clk count", !i[0], n_tx);
            clean();
        end
        $display("test baud done");
        // Trigger edges in capture and reload mode, enabled or not.
        for (int i = 0; i < 4; i++) begin
            c = {4'h0, i[1], 2'b00, i[0]};
            wr(tt_pkg::CTRL_OFF, {24'h0, c});
            ev(2);
            chk("capture_strobe count", i[1] && i[0], n_cp);
            chk("reload_strobe count", i[1] && !i[0], n_rl);
            rd(tt_pkg::CTRL_OFF, {24'h0, c | {1'b0, i[1], 6'h0}});
            chk("timer_irq", i[1], {31'h0, timer_irq});
            up_down_enable <= 1'b1;
            repeat (3) @(posedge clk);
            chk("timer_irq", 32'h0, {31'h0, timer_irq});
            up_down_enable <= 1'b0;
            clean();
        end
        $display("test trigger done");
        // Run bit and count source.
        wr(tt_pkg::CTRL_OFF, 32'h04);
        ev(4);
        ev(4);
        chk("count_tick count", 32'h3, n_tk);
        wr(tt_pkg::CTRL_OFF, 32'h06);
        ev(3);
        chk("count_tick count", 32'h1, n_tk);
        wr(tt_pkg::CTRL_OFF, 32'h02);
        ev(3);
        chk("count_tick count", 32'h0, n_tk);
        clean();
        $display("test counting done");
        final_report();
    end
endmodule // test_timer2_control_logic
